/* core/bwa_pkg.sv */
/*
  Package of the breaker wear accumulator: register map, reset values,
  setting limits, fixed-point formats, state codes and carrier structs.
  Assumes one 40 MHz clock and a synchronous active-low reset.
*/
package bwa_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CUR_W = 16;
  localparam int CNT_W = 17;
  localparam int FRAC_W = 12;
  localparam int LOG_W = 17;
  localparam int DIFF_W = 18;
  localparam int QUO_W = 48;
  localparam int TOT_INT_W = 32;
  localparam int TOT_W = TOT_INT_W + FRAC_W;
  localparam int EXP_INT_MAX = 20;

  // Register indices
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MIN_CUR = 8'h01;
  localparam logic [ADDR_W-1:0] REG_N_ONE = 8'h02;
  localparam logic [ADDR_W-1:0] REG_N_RATED = 8'h03;
  localparam logic [ADDR_W-1:0] REG_I_RATED = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ALM_LIM = 8'h05;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h06;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h07;
  localparam logic [ADDR_W-1:0] REG_WEAR_INT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_WEAR_FRAC = 8'h09;
  localparam logic [ADDR_W-1:0] REG_LAST_MAX = 8'h0A;

  // Field positions
  localparam int CTRL_OPER_BIT = 0;
  localparam int CMD_CLEAR_BIT = 0;
  localparam int ST_ALARM_BIT = 0;
  localparam int ST_ACQ_BIT = 1;
  localparam int ST_CALC_BIT = 2;
  localparam int ST_ABORT_BIT = 3;

  // Currents in units of 0.01 kA, then operation counts
  localparam logic [CUR_W-1:0] MIN_CUR_LO = 16'h000A;
  localparam logic [CUR_W-1:0] MIN_CUR_HI = 16'h0032;
  localparam logic [CUR_W-1:0] MIN_CUR_RST = 16'h000A;
  localparam logic [CUR_W-1:0] I_RATED_LO = 16'h03E8;
  localparam logic [CUR_W-1:0] I_RATED_HI = 16'h2710;
  localparam logic [CUR_W-1:0] I_RATED_RST = 16'h03E8;
  localparam logic [CNT_W-1:0] CNT_LO = 17'h00001;
  localparam logic [CNT_W-1:0] CNT_HI = 17'h186A0;
  localparam logic [CNT_W-1:0] N_ONE_RST = 17'h0C350;
  localparam logic [CNT_W-1:0] N_RATED_RST = 17'h00064;
  localparam logic [CNT_W-1:0] ALM_LIM_RST = 17'h0C350;

  // log2(100) as the log unit produces it, so 1 kA maps to exactly zero
  localparam logic [LOG_W-1:0] LOG2_ONE_KA = 17'h06900;
  localparam logic [FRAC_W:0] ONE_Q = 13'h1000;

  // Acquisition timeout
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int ACQ_TIMEOUT_MS = 1000;
  localparam int ACQ_TIMEOUT_CYC = CLK_FREQ_KHZ * ACQ_TIMEOUT_MS;

  // Synchronised pin indices
  localparam int NPIN = 5;
  localparam int PIN_TRIP = 0;
  localparam int PIN_CLOSED = 1;
  localparam int PIN_OPEN = 2;
  localparam int PIN_BLOCK = 3;
  localparam int PIN_RESET = 4;

  typedef enum logic [3:0] {
    BWA_IDLE = 4'h0,
    BWA_ACQ = 4'h1,
    BWA_LOG_N1 = 4'h2,
    BWA_LOG_NR = 4'h3,
    BWA_LOG_IR = 4'h4,
    BWA_LOG_IM = 4'h5,
    BWA_MULT = 4'h6,
    BWA_DIV = 4'h7,
    BWA_ADD = 4'h8
  } bwa_state_e;

  typedef struct packed {
    logic [CUR_W-1:0] l1;
    logic [CUR_W-1:0] l2;
    logic [CUR_W-1:0] l3;
  } bwa_phase_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bwa_bus_req_s;

endpackage : bwa_pkg

/* core/bwa_log2.sv */
/*
  Approximate base-2 logarithm: leading-one position as integer part,
  the bits below it as a linear fraction.
  Assumes a combinational path is acceptable within one clock.
*/
`timescale 1ns/1ps
module bwa_log2 #(
  parameter int IN_W = 32
) (
  input wire logic [IN_W-1:0] x,
  output logic [bwa_pkg::LOG_W-1:0] y
);

  logic [4:0] pos;
  logic [IN_W-1:0] norm;

  always_comb begin
    pos = 5'h00;
    for (int i = 0; i < IN_W; i++) begin
      if (x[i]) begin
        pos = 5'(i);
      end
    end
    // Zero input gives zero; callers never pass zero
    norm = x << (5'(IN_W - 1) - pos);
    y = {pos, norm[IN_W-2 -: bwa_pkg::FRAC_W]};
  end

endmodule : bwa_log2

/* core/bwa_wear_store.sv */
/*
  Wear total storage. Models the non-volatile cell: it has no reset,
  so the device reset leaves the total as it was.
  Assumes the writer clears it explicitly on first commissioning.
*/
`timescale 1ns/1ps
module bwa_wear_store #(
  parameter int W = bwa_pkg::TOT_W
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [W-1:0] wd,
  output logic [W-1:0] q
);

  always_ff @(posedge clk) begin
    if (we) begin
      q <= wd;
    end
  end

endmodule : bwa_wear_store

/* core/bwa_accumulator.sv */
/*
  Breaker wear accumulator top: pin synchronisers, settings registers,
  acquisition of the peak phase current, log-domain weighting and the
  wear total with its alarm.
  Assumes phase magnitudes come from same-clock measurement logic in
  units of 0.01 kA, and binary inputs come from pins.
*/
`timescale 1ns/1ps
module bwa_accumulator #(
  parameter int unsigned TIMEOUT_CYCLES = bwa_pkg::ACQ_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire bwa_pkg::bwa_bus_req_s bus_req,
  output logic [bwa_pkg::DATA_W-1:0] bus_rdata,
  input wire bwa_pkg::bwa_phase_s phase_mag,
  input wire logic trip_cmd,
  input wire logic breaker_closed_input,
  input wire logic breaker_open_input,
  input wire logic function_block_input,
  input wire logic wear_reset_input,
  output logic wear_alarm,
  output logic acquiring
);

  typedef struct packed {
    bwa_pkg::bwa_state_e st;
    logic [bwa_pkg::NPIN-1:0] sy1;
    logic [bwa_pkg::NPIN-1:0] sy2;
    logic [bwa_pkg::NPIN-1:0] sy3;
    logic [bwa_pkg::NPIN-1:0] filt;
    logic oper;
    logic [bwa_pkg::CUR_W-1:0] min_cur;
    logic [bwa_pkg::CNT_W-1:0] n_one;
    logic [bwa_pkg::CNT_W-1:0] n_rated;
    logic [bwa_pkg::CUR_W-1:0] i_rated;
    logic [bwa_pkg::CNT_W-1:0] alm_lim;
    logic [bwa_pkg::CUR_W-1:0] imax;
    logic [bwa_pkg::CUR_W-1:0] last_max;
    logic [31:0] tmr;
    logic [bwa_pkg::LOG_W-1:0] ln1;
    logic [bwa_pkg::LOG_W-1:0] lnr;
    logic [bwa_pkg::LOG_W-1:0] lir;
    logic [bwa_pkg::LOG_W-1:0] lim;
    logic neg;
    logic [bwa_pkg::DIFF_W-1:0] den;
    logic [bwa_pkg::DIFF_W-1:0] rem;
    logic [bwa_pkg::QUO_W-1:0] quo;
    logic [5:0] bitcnt;
    logic aborted;
    logic alarm;
    logic [bwa_pkg::DATA_W-1:0] rdata;
  } bwa_regs_s;

  bwa_regs_s r_r;
  bwa_regs_s r_nxt;

  logic [31:0] log_x;
  logic [bwa_pkg::LOG_W-1:0] log_y;
  logic store_we;
  logic [bwa_pkg::TOT_W-1:0] store_wd;
  logic [bwa_pkg::TOT_W-1:0] total;
  logic [bwa_pkg::CUR_W-1:0] cur_max;

  bwa_log2 #(
    .IN_W(32)
  ) u_log (
    .x(log_x),
    .y(log_y)
  );

  bwa_wear_store #(
    .W(bwa_pkg::TOT_W)
  ) u_store (
    .clk(clk),
    .we(store_we),
    .wd(store_wd),
    .q(total)
  );

  function automatic logic [bwa_pkg::CNT_W-1:0] clamp_cnt(
    input logic [bwa_pkg::DATA_W-1:0] v
  );
    return (v < 32'(bwa_pkg::CNT_LO)) ? bwa_pkg::CNT_LO :
           (v > 32'(bwa_pkg::CNT_HI)) ? bwa_pkg::CNT_HI :
           v[bwa_pkg::CNT_W-1:0];
  endfunction : clamp_cnt

  function automatic logic [bwa_pkg::CUR_W-1:0] clamp_cur(
    input logic [bwa_pkg::DATA_W-1:0] v,
    input logic [bwa_pkg::CUR_W-1:0] lo,
    input logic [bwa_pkg::CUR_W-1:0] hi
  );
    return (v < 32'(lo)) ? lo : (v > 32'(hi)) ? hi : v[bwa_pkg::CUR_W-1:0];
  endfunction : clamp_cur

  // Peak of the three fundamental magnitudes this sample
  always_comb begin
    cur_max = phase_mag.l1;
    if (phase_mag.l2 > cur_max) begin
      cur_max = phase_mag.l2;
    end
    if (phase_mag.l3 > cur_max) begin
      cur_max = phase_mag.l3;
    end
  end

  always_comb begin
    logic enabled;
    logic clr_cmd;
    logic clear;
    logic add_en;
    logic [bwa_pkg::TOT_W-1:0] addend;
    logic [bwa_pkg::TOT_W:0] sum;
    logic [bwa_pkg::CUR_W-1:0] peak;
    logic [bwa_pkg::DIFF_W-1:0] da;
    logic [bwa_pkg::DIFF_W-1:0] db;
    logic [bwa_pkg::DIFF_W-1:0] ma;
    logic [bwa_pkg::DIFF_W-1:0] mb;
    logic [bwa_pkg::DIFF_W:0] trial;
    logic [bwa_pkg::QUO_W-bwa_pkg::FRAC_W-1:0] eint;
    logic [bwa_pkg::TOT_W-1:0] mant;

    r_nxt = r_r;
    enabled = 1'b0;
    clr_cmd = 1'b0;
    clear = 1'b0;
    add_en = 1'b0;
    addend = '0;
    sum = '0;
    peak = '0;
    da = '0;
    db = '0;
    ma = '0;
    mb = '0;
    trial = '0;
    eint = '0;
    mant = '0;
    log_x = '0;
    store_we = 1'b0;
    store_wd = '0;

    // Three-stage pin sync; a change counts once stages two and three agree
    r_nxt.sy1 = {wear_reset_input, function_block_input, breaker_open_input,
                 breaker_closed_input, trip_cmd};
    r_nxt.sy2 = r_r.sy1;
    r_nxt.sy3 = r_r.sy2;
    r_nxt.filt = (r_r.sy2 & r_r.sy3) | (r_r.filt & (r_r.sy2 ^ r_r.sy3));

    enabled = r_r.oper & ~r_r.filt[bwa_pkg::PIN_BLOCK];

    // Register writes; out-of-range settings are clamped to their limits
    if (bus_req.wr) begin
      case (bus_req.addr)
        bwa_pkg::REG_CTRL: begin
          r_nxt.oper = bus_req.wdata[bwa_pkg::CTRL_OPER_BIT];
        end
        bwa_pkg::REG_MIN_CUR: begin
          r_nxt.min_cur = clamp_cur(bus_req.wdata, bwa_pkg::MIN_CUR_LO,
                                    bwa_pkg::MIN_CUR_HI);
        end
        bwa_pkg::REG_N_ONE: r_nxt.n_one = clamp_cnt(bus_req.wdata);
        bwa_pkg::REG_N_RATED: r_nxt.n_rated = clamp_cnt(bus_req.wdata);
        bwa_pkg::REG_I_RATED: begin
          r_nxt.i_rated = clamp_cur(bus_req.wdata, bwa_pkg::I_RATED_LO,
                                    bwa_pkg::I_RATED_HI);
        end
        bwa_pkg::REG_ALM_LIM: begin
          r_nxt.alm_lim = clamp_cnt(bus_req.wdata);
        end
        bwa_pkg::REG_CMD: begin
          clr_cmd = bus_req.wdata[bwa_pkg::CMD_CLEAR_BIT];
        end
        default: ;
      endcase
    end

    // Read data stand for exactly one cycle; unmapped reads give zero
    r_nxt.rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        bwa_pkg::REG_CTRL: r_nxt.rdata[bwa_pkg::CTRL_OPER_BIT] = r_r.oper;
        bwa_pkg::REG_MIN_CUR: r_nxt.rdata = 32'(r_r.min_cur);
        bwa_pkg::REG_N_ONE: r_nxt.rdata = 32'(r_r.n_one);
        bwa_pkg::REG_N_RATED: r_nxt.rdata = 32'(r_r.n_rated);
        bwa_pkg::REG_I_RATED: r_nxt.rdata = 32'(r_r.i_rated);
        bwa_pkg::REG_ALM_LIM: r_nxt.rdata = 32'(r_r.alm_lim);
        bwa_pkg::REG_STATUS: begin
          r_nxt.rdata[bwa_pkg::ST_ALARM_BIT] = r_r.alarm;
          r_nxt.rdata[bwa_pkg::ST_ACQ_BIT] = (r_r.st == bwa_pkg::BWA_ACQ);
          r_nxt.rdata[bwa_pkg::ST_CALC_BIT] =
            (r_r.st != bwa_pkg::BWA_ACQ) && (r_r.st != bwa_pkg::BWA_IDLE);
          r_nxt.rdata[bwa_pkg::ST_ABORT_BIT] = r_r.aborted;
        end
        bwa_pkg::REG_WEAR_INT: begin
          r_nxt.rdata = total[bwa_pkg::TOT_W-1:bwa_pkg::FRAC_W];
        end
        bwa_pkg::REG_WEAR_FRAC: r_nxt.rdata = 32'(total[bwa_pkg::FRAC_W-1:0]);
        bwa_pkg::REG_LAST_MAX: r_nxt.rdata = 32'(r_r.last_max);
        default: ;
      endcase
    end

    peak = (cur_max > r_r.imax) ? cur_max : r_r.imax;

    case (r_r.st)
      bwa_pkg::BWA_IDLE: begin
        if (enabled && r_r.filt[bwa_pkg::PIN_TRIP] &&
            r_r.filt[bwa_pkg::PIN_CLOSED]) begin
          r_nxt.st = bwa_pkg::BWA_ACQ;
          r_nxt.imax = cur_max;
          r_nxt.tmr = '0;
        end
      end
      bwa_pkg::BWA_ACQ: begin
        r_nxt.imax = peak;
        r_nxt.tmr = r_r.tmr + 32'h00000001;
        if (r_r.tmr >= 32'(TIMEOUT_CYCLES)) begin
          r_nxt.st = bwa_pkg::BWA_IDLE;
          r_nxt.aborted = 1'b1;
        end else if (cur_max < r_r.min_cur &&
                     r_r.filt[bwa_pkg::PIN_OPEN]) begin
          r_nxt.st = bwa_pkg::BWA_LOG_N1;
          r_nxt.last_max = peak;
          r_nxt.aborted = 1'b0;
        end
      end
      bwa_pkg::BWA_LOG_N1: begin
        log_x = 32'(r_r.n_one);
        r_nxt.ln1 = log_y;
        r_nxt.st = bwa_pkg::BWA_LOG_NR;
      end
      bwa_pkg::BWA_LOG_NR: begin
        log_x = 32'(r_r.n_rated);
        r_nxt.lnr = log_y;
        r_nxt.st = bwa_pkg::BWA_LOG_IR;
      end
      bwa_pkg::BWA_LOG_IR: begin
        log_x = 32'(r_r.i_rated);
        r_nxt.lir = log_y;
        r_nxt.st = bwa_pkg::BWA_LOG_IM;
      end
      bwa_pkg::BWA_LOG_IM: begin
        // A zero peak is taken as the smallest step to keep the log finite
        log_x = (r_r.last_max == '0) ? 32'h00000001 : 32'(r_r.last_max);
        r_nxt.lim = log_y;
        r_nxt.st = bwa_pkg::BWA_MULT;
      end
      bwa_pkg::BWA_MULT: begin
        // Exponent k*log2(I/1kA) = (ln1-lnr)*(lim-l1ka)/(lir-l1ka)
        da = 18'({1'b0, r_r.ln1}) - 18'({1'b0, r_r.lnr});
        db = 18'({1'b0, r_r.lim}) - 18'({1'b0, bwa_pkg::LOG2_ONE_KA});
        ma = da[bwa_pkg::DIFF_W-1] ? -da : da;
        mb = db[bwa_pkg::DIFF_W-1] ? -db : db;
        r_nxt.neg = da[bwa_pkg::DIFF_W-1] ^ db[bwa_pkg::DIFF_W-1];
        // Q24 product over a Q12 divisor leaves the exponent in Q12
        r_nxt.quo = bwa_pkg::QUO_W'(36'(ma) * 36'(mb));
        r_nxt.den = 18'({1'b0, r_r.lir}) -
                    18'({1'b0, bwa_pkg::LOG2_ONE_KA});
        r_nxt.rem = '0;
        r_nxt.bitcnt = '0;
        r_nxt.st = bwa_pkg::BWA_DIV;
      end
      bwa_pkg::BWA_DIV: begin
        // Restoring division, one quotient bit a cycle
        trial = {r_r.rem, r_r.quo[bwa_pkg::QUO_W-1]};
        if (trial >= {1'b0, r_r.den}) begin
          r_nxt.rem = bwa_pkg::DIFF_W'(trial - {1'b0, r_r.den});
          r_nxt.quo = {r_r.quo[bwa_pkg::QUO_W-2:0], 1'b1};
        end else begin
          r_nxt.rem = trial[bwa_pkg::DIFF_W-1:0];
          r_nxt.quo = {r_r.quo[bwa_pkg::QUO_W-2:0], 1'b0};
        end
        r_nxt.bitcnt = r_r.bitcnt + 6'h01;
        if (r_r.bitcnt == 6'(bwa_pkg::QUO_W - 1)) begin
          r_nxt.st = bwa_pkg::BWA_ADD;
        end
      end
      bwa_pkg::BWA_ADD: begin
        // 2^e approximated as (1+frac) shifted by the integer part
        eint = r_r.quo[bwa_pkg::QUO_W-1:bwa_pkg::FRAC_W];
        mant = bwa_pkg::TOT_W'({1'b1, r_r.quo[bwa_pkg::FRAC_W-1:0]});
        if (!r_r.neg) begin
          if (eint > 36'(bwa_pkg::EXP_INT_MAX)) begin
            addend = mant << bwa_pkg::EXP_INT_MAX;
          end else begin
            addend = mant << eint;
          end
        end else if (eint <= 36'(bwa_pkg::FRAC_W)) begin
          addend = mant >> eint;
        end
        add_en = 1'b1;
        r_nxt.st = bwa_pkg::BWA_IDLE;
      end
      default: begin
        r_nxt.st = bwa_pkg::BWA_IDLE;
      end
    endcase

    // Suspend drops any acquisition or calculation in progress, except an add step that meets a clear
    if (!enabled && r_r.st != bwa_pkg::BWA_IDLE) begin
      r_nxt.st = bwa_pkg::BWA_IDLE;
      add_en = 1'b0;
    end

    // Clear and a same-cycle addition both count: total becomes the addend
    clear = r_r.filt[bwa_pkg::PIN_RESET] | clr_cmd;
    sum = {1'b0, clear ? bwa_pkg::TOT_W'(0) : total} + {1'b0, addend};
    if (clear || add_en) begin
      store_we = 1'b1;
      store_wd = sum[bwa_pkg::TOT_W] ? '1 : sum[bwa_pkg::TOT_W-1:0];
    end

    r_nxt.alarm = enabled &&
      (total[bwa_pkg::TOT_W-1:bwa_pkg::FRAC_W] >= 32'(r_r.alm_lim));
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r_r <= '0;
      r_r.st <= bwa_pkg::BWA_IDLE;
      r_r.min_cur <= bwa_pkg::MIN_CUR_RST;
      r_r.n_one <= bwa_pkg::N_ONE_RST;
      r_r.n_rated <= bwa_pkg::N_RATED_RST;
      r_r.i_rated <= bwa_pkg::I_RATED_RST;
      r_r.alm_lim <= bwa_pkg::ALM_LIM_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign bus_rdata = r_r.rdata;
  assign wear_alarm = r_r.alarm;
  assign acquiring = (r_r.st == bwa_pkg::BWA_ACQ);

endmodule : bwa_accumulator

/* verif/bwa_accum_props.sv */
/*
  Checker for the breaker wear accumulator top, bound to its ports.
  Assumes the 3-flop pin synchronisers give 4 cycles from pin to state.
*/
`timescale 1ns/1ps
module bwa_accum_props #(
  parameter int unsigned TIMEOUT_CYCLES = 200
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire bwa_pkg::bwa_bus_req_s bus_req,
  input wire logic [bwa_pkg::DATA_W-1:0] bus_rdata,
  input wire logic trip_cmd,
  input wire logic breaker_closed_input,
  input wire logic breaker_open_input,
  input wire logic function_block_input,
  input wire logic wear_reset_input,
  input wire logic wear_alarm,
  input wire logic acquiring
);
  // Cycles spent in acquisition so far; a repetition cannot reach 1 s
  logic [31:0] acq_cnt_r;
  always_ff @(posedge clk) begin
    if (!reset_n || !acquiring)
      acq_cnt_r <= '0;
    else
      acq_cnt_r <= acq_cnt_r + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
    else $error("read data not zero outside read answer");
  a_start_trip: assert property ($rose(acquiring) |-> $past(trip_cmd, 4))
    else $error("acquisition began without trip command");
  a_start_closed: assert property (
    $rose(acquiring) |-> $past(breaker_closed_input, 4))
    else $error("acquisition began with breaker not closed");
  a_idle_nostart: assert property (
    !trip_cmd [*6] |-> !$rose(acquiring))
    else $error("acquisition began long after trip fell");
  a_block_quiet: assert property (
    function_block_input [*6] |-> !acquiring && !wear_alarm)
    else $error("activity while function blocked");
  a_acq_bound: assert property (
    acquiring |-> acq_cnt_r <= TIMEOUT_CYCLES)
    else $error("acquisition outlived its timeout");
  a_end_open: assert property (
    $fell(acquiring) && acq_cnt_r < TIMEOUT_CYCLES
    |-> $past(breaker_open_input, 4))
    else $error("acquisition ended with breaker not open");
  a_wreset_clear: assert property (
    wear_reset_input [*7] |-> !wear_alarm)
    else $error("alarm stands while total is held clear");
  a_alarm_rise: assert property (
    $rose(wear_alarm) |-> !$past(function_block_input, 4))
    else $error("alarm rose while blocked");
  c_acq: cover property ($rose(acquiring));
  c_alarm: cover property ($rose(wear_alarm));
  c_timeout: cover property (acq_cnt_r == TIMEOUT_CYCLES);
endmodule : bwa_accum_props

bind bwa_accumulator bwa_accum_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
  u_props (
  .clk(clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .trip_cmd(trip_cmd), .breaker_closed_input(breaker_closed_input),
  .breaker_open_input(breaker_open_input),
  .function_block_input(function_block_input),
  .wear_reset_input(wear_reset_input), .wear_alarm(wear_alarm),
  .acquiring(acquiring));

/* verif/bwa_breaker_model.sv */
/*
  Breaker and current measurement model: trip command, status contacts
  and three phase magnitudes in units of 0.01 kA.
  Assumes the bench pulses fire for one cycle per interruption.
*/
`timescale 1ns/1ps
module bwa_breaker_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic [bwa_pkg::CUR_W-1:0] peak,
  input wire logic stuck,
  input wire logic hold_open,
  output logic trip_cmd,
  output logic breaker_closed_input,
  output logic breaker_open_input,
  output bwa_pkg::bwa_phase_s phase_mag
);
  localparam int HOLD = 30;
  logic busy_r = 1'b0;
  logic open_r = 1'b0;
  logic trip_r = 1'b0;
  int cnt_r = 0;
  bwa_pkg::bwa_phase_s mag_r = '0;
  always @(posedge clk) begin
    if (fire && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r <= 0;
      trip_r <= 1'b1;
      mag_r <= '{l1: peak >> 1, l2: peak, l3: peak >> 2};
    end else if (busy_r) begin
      cnt_r <= cnt_r + 1;
      // Peak fades mid-fault so only a running maximum keeps it
      if (cnt_r == HOLD / 2)
        mag_r.l2 <= peak >> 1;
      if (cnt_r == HOLD) begin
        mag_r <= '0;
        trip_r <= 1'b0;
        open_r <= !stuck;
      end
      if (cnt_r == HOLD + 40) begin
        busy_r <= 1'b0;
        open_r <= 1'b0;
      end
    end
  end
  assign trip_cmd = trip_r;
  // The two contacts always disagree, as on a healthy breaker
  assign breaker_open_input = open_r || hold_open;
  assign breaker_closed_input = !breaker_open_input;
  assign phase_mag = mag_r;
endmodule : bwa_breaker_model

/* verif/bwa_accumulator_tb.sv */
/*
  Self-checking bench of the wear accumulator: register bus tasks and
  interruption sequences through the breaker model.
  Assumes a short acquisition timeout parameter for simulation.
*/
`timescale 1ns/1ps
module bwa_accumulator_tb;
  localparam int unsigned TMO = 200;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  bwa_pkg::bwa_bus_req_s bus_req = '0;
  logic [bwa_pkg::DATA_W-1:0] bus_rdata;
  bwa_pkg::bwa_phase_s phase_mag;
  logic trip_cmd;
  logic breaker_closed_input;
  logic breaker_open_input;
  logic function_block_input = 1'b0;
  logic wear_reset_input = 1'b0;
  logic wear_alarm;
  logic acquiring;
  logic fire = 1'b0;
  logic stuck = 1'b0;
  logic hold_open = 1'b0;
  logic [bwa_pkg::CUR_W-1:0] peak = '0;
  logic [31:0] v;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int up;
  always #12.5 clk = ~clk;
  bwa_accumulator #(.TIMEOUT_CYCLES(TMO)) DUT (
    .clk(clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .phase_mag(phase_mag), .trip_cmd(trip_cmd),
    .breaker_closed_input(breaker_closed_input),
    .breaker_open_input(breaker_open_input),
    .function_block_input(function_block_input),
    .wear_reset_input(wear_reset_input), .wear_alarm(wear_alarm),
    .acquiring(acquiring));
  bwa_breaker_model u_brk (
    .clk(clk), .fire(fire), .peak(peak), .stuck(stuck),
    .hold_open(hold_open), .trip_cmd(trip_cmd),
    .breaker_closed_input(breaker_closed_input),
    .breaker_open_input(breaker_open_input), .phase_mag(phase_mag));
  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe, so sample just past it
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(v, exp);
  endtask : rd_chk
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : ticks
  // Window covers a full timeout and the weighting that follows an end
  task automatic op(input logic [15:0] pk, input logic stk);
    @(posedge clk);
    peak <= pk;
    stuck <= stk;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    up = 0;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (acquiring === 1'b1)
        up++;
    end
  endtask : op
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    wr(bwa_pkg::REG_CMD, 32'h1);
    rd_chk(bwa_pkg::REG_WEAR_INT, 32'h0);
    rd_chk(bwa_pkg::REG_WEAR_FRAC, 32'h0);
    rd_chk(bwa_pkg::REG_CTRL, 32'h0);
    rd_chk(bwa_pkg::REG_MIN_CUR, 32'hA);
    rd_chk(bwa_pkg::REG_N_ONE, 32'hC350);
    rd_chk(bwa_pkg::REG_N_RATED, 32'h64);
    rd_chk(bwa_pkg::REG_I_RATED, 32'h3E8);
    rd_chk(bwa_pkg::REG_ALM_LIM, 32'hC350);
    rd_chk(bwa_pkg::REG_STATUS, 32'h0);
    wr(8'h30, 32'h5);
    rd_chk(8'h30, 32'h0);
    wr(bwa_pkg::REG_WEAR_INT, 32'h5);
    rd_chk(bwa_pkg::REG_WEAR_INT, 32'h0);
    wr(bwa_pkg::REG_MIN_CUR, 32'h64);
    rd_chk(bwa_pkg::REG_MIN_CUR, 32'h32);
    wr(bwa_pkg::REG_MIN_CUR, 32'h0);
    rd_chk(bwa_pkg::REG_MIN_CUR, 32'hA);
    wr(bwa_pkg::REG_ALM_LIM, 32'h0);
    rd_chk(bwa_pkg::REG_ALM_LIM, 32'h1);
    wr(bwa_pkg::REG_ALM_LIM, 32'h2);
    op(16'h0064, 1'b0);
    chk(32'(up), 32'h0);
    wr(bwa_pkg::REG_CTRL, 32'h1);
    function_block_input <= 1'b1;
    op(16'h0064, 1'b0);
    chk(32'(up), 32'h0);
    function_block_input <= 1'b0;
    hold_open <= 1'b1;
    op(16'h0064, 1'b0);
    chk(32'(up), 32'h0);
    hold_open <= 1'b0;
    op(16'h0064, 1'b0);
    chk({31'h0, (up > 0 && up < TMO)}, 32'h1);
    rd_chk(bwa_pkg::REG_WEAR_INT, 32'h1);
    rd_chk(bwa_pkg::REG_WEAR_FRAC, 32'h0);
    rd_chk(bwa_pkg::REG_LAST_MAX, 32'h64);
    chk({31'h0, wear_alarm}, 32'h0);
    op(16'h0064, 1'b1);
    chk(32'(up), 32'(TMO + 1));
    rd(bwa_pkg::REG_STATUS);
    chk({31'h0, v[bwa_pkg::ST_ABORT_BIT]}, 32'h1);
    rd_chk(bwa_pkg::REG_WEAR_INT, 32'h1);
    op(16'h0064, 1'b0);
    rd_chk(bwa_pkg::REG_WEAR_INT, 32'h2);
    chk({31'h0, wear_alarm}, 32'h1);
    function_block_input <= 1'b1;
    ticks(8);
    chk({31'h0, wear_alarm}, 32'h0);
    function_block_input <= 1'b0;
    ticks(8);
    chk({31'h0, wear_alarm}, 32'h1);
    reset_n <= 1'b0;
    ticks(2);
    reset_n <= 1'b1;
    rd_chk(bwa_pkg::REG_WEAR_INT, 32'h2);
    chk({31'h0, wear_alarm}, 32'h0);
    wr(bwa_pkg::REG_ALM_LIM, 32'h2);
    wr(bwa_pkg::REG_CTRL, 32'h1);
    ticks(2);
    chk({31'h0, wear_alarm}, 32'h1);
    wear_reset_input <= 1'b1;
    ticks(8);
    chk({31'h0, wear_alarm}, 32'h0);
    wear_reset_input <= 1'b0;
    ticks(6);
    rd_chk(bwa_pkg::REG_WEAR_INT, 32'h0);
    op(16'h03E8, 1'b0);
    rd(bwa_pkg::REG_WEAR_INT);
    chk({31'h0, (v >= 32'h1DB && v <= 32'h20D)}, 32'h1);
    tally_and_finish();
  end
endmodule : bwa_accumulator_tb
